// ### scaw_core.sv
// star coupler wake detection, activity/idle detection, signal routing and branch error flags
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////////////////////////////
module scaw_core
    import scaw_pkg::*;
(
    // clock and reset
    input  wire logic                clock_in,
    input  wire logic                sys_rst_in,
    // mode and supply status
    input  wire scaw_mode_e          mode_in,
    input  wire logic                io_uv_in,
    // communication controller side
    input  wire logic                txd_in,
    input  wire logic                tx_en_n_in,
    input  wire logic                bus_guard_en_in,
    output logic                     rxd_out,
    // local wake pin
    input  wire logic                local_wake_in,
    output logic                     local_wake_pulldown_out,
    // inner-star lines, open drain
    input  wire logic                inner_star_line0_in,
    input  wire logic                inner_star_line1_in,
    output logic                     inner_star_line0_out,
    output logic                     inner_star_line0_oe_out,
    output logic                     inner_star_line1_out,
    output logic                     inner_star_line1_oe_out,
    // bus branches
    input  wire scaw_branch_s [NUM_BR-1:0] branch_in,
    output scaw_sym_e                bus_sym_out,
    output logic                     bus_tx_on_out,
    output logic                     bus_bias_gnd_out,
    output logic                     bus_float_out,
    // status flags, cleared from outside, and one-cycle interrupts
    input  wire logic                local_wake_clr_in,
    input  wire logic                inner_star_wake_clr_in,
    input  wire logic [NUM_BR-1:0]   branch_tx_error_clr_in,
    output logic                     local_wake_flag_out,
    output logic                     inner_star_wake_flag_out,
    output logic [NUM_BR-1:0]        branch_tx_error_flag_out,
    output logic                     wake_interrupt_out,
    output logic [NUM_BR-1:0]        branch_event_interrupt_out,
    // activity status
    output logic                     bus_active_out,
    output logic                     tx_active_out,
    output logic                     inner_star_active_out,
    output logic                     fifo_ready_out
);

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // filter counters: each restarts when its condition breaks

    localparam int NF = 9;
    // index map of filters
    localparam int F_LWU_LO = 0;
    localparam int F_LWU_HI = 1;
    localparam int F_ISWAKE = 2;
    localparam int F_BUSACT = 3;
    localparam int F_BUSIDL = 4;
    localparam int F_TXACT  = 5;
    localparam int F_TXIDL  = 6;
    localparam int F_ISACT  = 7;
    localparam int F_ISIDL  = 8;

    localparam logic [NF-1:0][CNT_W-1:0] F_LIMIT = {
        CNT_W'(CYC_IS_IDLE), CNT_W'(CYC_IS_ACT), CNT_W'(CYC_TXEN_IDLE), CNT_W'(CYC_TXEN_ACT),
        CNT_W'(CYC_BUS_IDLE), CNT_W'(CYC_BUS_ACT), CNT_W'(CYC_IS_WAKE), CNT_W'(CYC_LWU), CNT_W'(CYC_LWU)
    };

    logic              bus_act_raw;
    logic              bus_act_bridged;
    logic [CNT_W-1:0]  gap_cnt;
    logic              is_any_low;
    logic [NF-1:0]     f_cond;
    logic [NF-1:0]     f_hit;

    // a line pulled low by our own driver is not inner-star input, else the star would echo itself
    assign is_any_low  = (!inner_star_line0_in && !inner_star_line0_oe_out)
                         || (!inner_star_line1_in && !inner_star_line1_oe_out);
    assign bus_act_raw = branch_in[0].act || branch_in[1].act;

    // short dropouts of activity (byte start gaps) are bridged so the bus idle filter does not fire inside a frame
    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            gap_cnt <= '0;
        end
        else if (bus_act_raw)
        begin
            gap_cnt <= '0;
        end
        else if (gap_cnt != CNT_W'(CYC_BSS_GAP))
        begin
            gap_cnt <= gap_cnt + CNT_W'(1);
        end
    end
    assign bus_act_bridged = bus_act_raw || (gap_cnt != CNT_W'(CYC_BSS_GAP));

    always_comb
    begin
        f_cond           = '0;
        f_cond[F_LWU_LO] = !local_wake_in;
        f_cond[F_LWU_HI] = local_wake_in;
        f_cond[F_ISWAKE] = is_any_low;
        f_cond[F_BUSACT] = bus_act_raw;
        f_cond[F_BUSIDL] = !bus_act_bridged;
        f_cond[F_TXACT]  = !tx_en_n_in;
        f_cond[F_TXIDL]  = tx_en_n_in;
        f_cond[F_ISACT]  = is_any_low;
        f_cond[F_ISIDL]  = !is_any_low;
    end

    generate
        for (genvar g = 0; g < NF; g++)
        begin : g_filt
            logic [CNT_W-1:0] cnt;
            always_ff @(posedge clock_in or posedge sys_rst_in)
            begin
                if (sys_rst_in)
                begin
                    cnt <= '0;
                end
                else if (!f_cond[g])
                begin
                    cnt <= '0;
                end
                else if (cnt != F_LIMIT[g])
                begin
                    cnt <= cnt + CNT_W'(1);
                end
            end
            assign f_hit[g]  = f_cond[g] && (cnt == F_LIMIT[g] - CNT_W'(1));
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // local and inner-star wake

    logic powered;
    assign powered = (mode_in != SCAW_MODE_OFF) && (mode_in != SCAW_MODE_RESET);

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            local_wake_pulldown_out <= 1'b0;
        end
        else if (f_hit[F_LWU_LO])
        begin
            local_wake_pulldown_out <= 1'b1;
        end
        else if (f_hit[F_LWU_HI])
        begin
            local_wake_pulldown_out <= 1'b0;
        end
    end

    logic lwu_event;
    logic isw_event;
    assign lwu_event = powered && f_hit[F_LWU_LO] && !local_wake_pulldown_out;
    assign isw_event = powered && f_hit[F_ISWAKE];

    // set wins over clear on every flag
    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            local_wake_flag_out      <= 1'b0;
            inner_star_wake_flag_out <= 1'b0;
        end
        else
        begin
            local_wake_flag_out      <= lwu_event || (local_wake_flag_out && !local_wake_clr_in);
            inner_star_wake_flag_out <= isw_event || (inner_star_wake_flag_out && !inner_star_wake_clr_in);
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            wake_interrupt_out <= 1'b0;
        end
        else
        begin
            wake_interrupt_out <= lwu_event || isw_event;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // activity / idle state per input channel

    logic normal;
    assign normal = (mode_in == SCAW_MODE_NORMAL);

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            bus_active_out        <= 1'b0;
            tx_active_out         <= 1'b0;
            inner_star_active_out <= 1'b0;
        end
        else
        begin
            if (!normal || f_hit[F_BUSIDL])
            begin
                bus_active_out <= 1'b0;
            end
            else if (f_hit[F_BUSACT])
            begin
                bus_active_out <= 1'b1;
            end
            if (f_hit[F_TXIDL])
            begin
                tx_active_out <= 1'b0;
            end
            else if (f_hit[F_TXACT])
            begin
                tx_active_out <= 1'b1;
            end
            if (f_hit[F_ISIDL])
            begin
                inner_star_active_out <= 1'b0;
            end
            else if (f_hit[F_ISACT])
            begin
                inner_star_active_out <= 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // source arbitration: first active channel holds until it goes idle

    scaw_src_e src;
    scaw_src_e next_src;
    logic      tx_gate;
    logic      txd_q;
    logic      tx_started;

    assign tx_gate = !tx_en_n_in && bus_guard_en_in;

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            txd_q      <= 1'b1;
            tx_started <= 1'b0;
        end
        else
        begin
            txd_q <= txd_in;
            if (!tx_gate || !normal)
            begin
                tx_started <= 1'b0;
            end
            else if (txd_q && !txd_in)
            begin
                tx_started <= 1'b1;
            end
        end
    end

    always_comb
    begin
        next_src = src;
        unique case (src)
            SCAW_SRC_NONE:
            begin
                if (tx_started)
                begin
                    next_src = SCAW_SRC_TX;
                end
                else if (bus_active_out)
                begin
                    next_src = SCAW_SRC_BUS;
                end
                else if (inner_star_active_out)
                begin
                    next_src = SCAW_SRC_IS;
                end
            end
            SCAW_SRC_TX:
            begin
                if (!tx_started)
                begin
                    next_src = SCAW_SRC_NONE;
                end
            end
            SCAW_SRC_BUS:
            begin
                if (!bus_active_out)
                begin
                    next_src = SCAW_SRC_NONE;
                end
            end
            SCAW_SRC_IS:
            begin
                if (!inner_star_active_out)
                begin
                    next_src = SCAW_SRC_NONE;
                end
            end
        endcase
        if (!normal)
        begin
            next_src = SCAW_SRC_NONE;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            src <= SCAW_SRC_NONE;
        end
        else
        begin
            src <= next_src;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // symbol selection, buffered in a fifo before the output stage

    scaw_sym_e  sym;
    scaw_word_s wr_word;
    scaw_word_s rd_word;
    logic       rd_valid;
    logic       bus_high;
    logic       bus_low;

    assign bus_high = branch_in[0].high || branch_in[1].high;
    assign bus_low  = branch_in[0].low || branch_in[1].low;

    always_comb
    begin
        sym = SCAW_SYM_IDLE;
        unique case (src)
            SCAW_SRC_NONE: sym = SCAW_SYM_IDLE;
            SCAW_SRC_TX:   sym = txd_in ? SCAW_SYM_D1 : SCAW_SYM_D0;
            SCAW_SRC_BUS:  sym = bus_low ? SCAW_SYM_D0 : (bus_high ? SCAW_SYM_D1 : SCAW_SYM_IDLE);
            SCAW_SRC_IS:   sym = !inner_star_line0_in ? SCAW_SYM_D0
                               : (!inner_star_line1_in ? SCAW_SYM_D1 : SCAW_SYM_IDLE);
        endcase
    end

    assign wr_word = '{src: src, sym: sym};

    // the output stage always drains, so the fifo only adds latency; ready is exposed for status
    scaw_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock_in     (clock_in),
        .sys_rst_in   (sys_rst_in),
        .wr_valid_in  (1'b1),
        .wr_data_in   (wr_word),
        .wr_ready_out (fifo_ready_out),
        .rd_valid_out (rd_valid),
        .rd_data_out  (rd_word),
        .rd_ready_in  (1'b1)
    );

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // output stage

    scaw_sym_e osym;
    scaw_src_e osrc;
    assign osym = rd_valid ? rd_word.sym : SCAW_SYM_IDLE;
    assign osrc = rd_valid ? rd_word.src : SCAW_SRC_NONE;

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            rxd_out                 <= 1'b1;
            bus_sym_out             <= SCAW_SYM_IDLE;
            bus_tx_on_out           <= 1'b0;
            inner_star_line0_out    <= 1'b0;
            inner_star_line0_oe_out <= 1'b0;
            inner_star_line1_out    <= 1'b0;
            inner_star_line1_oe_out <= 1'b0;
        end
        else
        begin
            inner_star_line0_out <= 1'b0;
            inner_star_line1_out <= 1'b0;
            if (!powered)
            begin
                rxd_out <= 1'b1;
            end
            else if (io_uv_in)
            begin
                rxd_out <= 1'b0;
            end
            else
            begin
                rxd_out <= (normal && osym == SCAW_SYM_D0) ? 1'b0 : 1'b1;
            end
            // bus is driven from transmit or inner-star source only, never from itself
            bus_tx_on_out <= normal && !io_uv_in && (osrc == SCAW_SRC_TX || osrc == SCAW_SRC_IS);
            bus_sym_out   <= (normal && !io_uv_in && osrc != SCAW_SRC_BUS) ? osym : SCAW_SYM_IDLE;
            // inner lines mirror tx or bus sources, never the inner-star source itself
            inner_star_line0_oe_out <= normal && osym == SCAW_SYM_D0 && osrc != SCAW_SRC_IS
                                       && !(osrc == SCAW_SRC_TX && io_uv_in);
            inner_star_line1_oe_out <= normal && osym == SCAW_SYM_D1 && osrc != SCAW_SRC_IS
                                       && !(osrc == SCAW_SRC_TX && io_uv_in);
        end
    end

    assign bus_bias_gnd_out = (mode_in == SCAW_MODE_STANDBY) || (mode_in == SCAW_MODE_SLEEP);
    assign bus_float_out    = !powered;

    //////////////////////////////////////////////////////////////////////////////////////////////////
    // branch transmit error flags

    generate
        for (genvar b = 0; b < NUM_BR; b++)
        begin : g_br
            logic err;
            assign err = bus_tx_on_out && (branch_in[b].short_bp_bm || branch_in[b].short_gnd
                                           || branch_in[b].short_sup);
            always_ff @(posedge clock_in or posedge sys_rst_in)
            begin
                if (sys_rst_in)
                begin
                    branch_tx_error_flag_out[b]   <= 1'b0;
                    branch_event_interrupt_out[b] <= 1'b0;
                end
                else
                begin
                    branch_tx_error_flag_out[b]   <= err || (branch_tx_error_flag_out[b]
                                                             && !branch_tx_error_clr_in[b]);
                    branch_event_interrupt_out[b] <= err && !branch_tx_error_flag_out[b];
                end
            end
        end
    endgenerate

endmodule : scaw_core

// ### scaw_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module scaw_fifo
#(
    parameter int unsigned WIDTH = 6,
    parameter int unsigned DEPTH = 8
)
(
    // clock and reset
    input  wire logic             clock_in,
    input  wire logic             sys_rst_in,
    // fill side
    input  wire logic             wr_valid_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    output logic                  wr_ready_out,
    // drain side
    output logic                  rd_valid_out,
    output logic [WIDTH-1:0]      rd_data_out,
    input  wire logic             rd_ready_in
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             do_wr;
    logic             do_rd;

    assign wr_ready_out = (count != (AW+1)'(DEPTH));
    assign rd_valid_out = (count != '0);
    assign do_wr        = wr_valid_in && wr_ready_out;
    assign do_rd        = rd_valid_out && rd_ready_in;
    assign rd_data_out  = mem[rd_ptr];

    always_ff @(posedge clock_in)
    begin
        if (do_wr)
        begin
            mem[wr_ptr] <= wr_data_in;
        end
    end

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
            end
            if (do_rd)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
            end
            if (do_wr && !do_rd)
            begin
                count <= count + (AW+1)'(1);
            end
            else if (do_rd && !do_wr)
            begin
                count <= count - (AW+1)'(1);
            end
        end
    end

endmodule : scaw_fifo

// ### scaw_peer.sv
// neighbour star coupler on the inner-star pair; lines have pull-ups
`timescale 1ns/1ps
module scaw_peer
(
    input  wire logic [1:0] dut_oe_in,
    input  wire logic [1:0] pull_in,
    output logic [1:0]      line_out
);
    // wired-and of both open-drain drivers over the pull-up
    assign line_out = ~(dut_oe_in | pull_in);
endmodule : scaw_peer

// ### scaw_pkg.sv
// package: shared constants, types and timing counts for the star activity and wake logic
package scaw_pkg;

    localparam int unsigned CLK_PERIOD_NS = 40;

    // filter times in ns; cycle counts round up to whole cycles
    localparam int unsigned T_LWU_NS       = 50000;
    localparam int unsigned T_IS_WAKE_NS   = 1000;
    localparam int unsigned T_BUS_ACT_NS   = 200;
    localparam int unsigned T_BUS_IDLE_NS  = 200;
    localparam int unsigned T_TXEN_ACT_NS  = 200;
    localparam int unsigned T_TXEN_IDLE_NS = 200;
    localparam int unsigned T_IS_ACT_NS    = 200;
    localparam int unsigned T_IS_IDLE_NS   = 200;
    // byte start gap that the bus idle filter must bridge
    localparam int unsigned T_BSS_GAP_NS   = 130;

    localparam int unsigned CYC_LWU       = (T_LWU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_IS_WAKE   = (T_IS_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_BUS_ACT   = (T_BUS_ACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_BUS_IDLE  = (T_BUS_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_TXEN_ACT  = (T_TXEN_ACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_TXEN_IDLE = (T_TXEN_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_IS_ACT    = (T_IS_ACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_IS_IDLE   = (T_IS_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CYC_BSS_GAP   = (T_BSS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned CNT_W      = 11;
    localparam int unsigned NUM_BR     = 2;
    localparam int unsigned FIFO_DEPTH = 8;

    // operating modes of the surrounding mode machine
    typedef enum logic [4:0] {
        SCAW_MODE_OFF     = 5'b0_0001,
        SCAW_MODE_RESET   = 5'b0_0010,
        SCAW_MODE_STANDBY = 5'b0_0100,
        SCAW_MODE_SLEEP   = 5'b0_1000,
        SCAW_MODE_NORMAL  = 5'b1_0000
    } scaw_mode_e;

    // forwarding source, one-hot
    typedef enum logic [3:0] {
        SCAW_SRC_NONE = 4'b0001,
        SCAW_SRC_TX   = 4'b0010,
        SCAW_SRC_BUS  = 4'b0100,
        SCAW_SRC_IS   = 4'b1000
    } scaw_src_e;

    // bus symbol code: idle, data_0, data_1
    typedef enum logic [1:0] {
        SCAW_SYM_IDLE = 2'h0,
        SCAW_SYM_D0   = 2'h1,
        SCAW_SYM_D1   = 2'h2
    } scaw_sym_e;

    // per-branch analog comparator results
    typedef struct packed {
        logic act;
        logic high;
        logic low;
        logic short_bp_bm;
        logic short_gnd;
        logic short_sup;
    } scaw_branch_s;

    // symbol word carried through the output fifo
    typedef struct packed {
        scaw_src_e src;
        scaw_sym_e sym;
    } scaw_word_s;

    localparam int unsigned WORD_W = $bits(scaw_word_s);

endpackage : scaw_pkg

// ### scaw_props.sv
// checker: port relations of the star activity and wake core
`timescale 1ns/1ps
module scaw_props
    import scaw_pkg::*;
(
    input wire logic              clock_in,
    input wire logic              sys_rst_in,
    input wire scaw_mode_e        mode_in,
    input wire logic              io_uv_in,
    input wire logic              local_wake_clr_in,
    input wire logic [NUM_BR-1:0] branch_tx_error_clr_in,
    input wire logic              rxd_out,
    input wire logic              local_wake_pulldown_out,
    input wire logic              local_wake_flag_out,
    input wire logic              inner_star_wake_flag_out,
    input wire logic [NUM_BR-1:0] branch_tx_error_flag_out,
    input wire logic              wake_interrupt_out,
    input wire logic              bus_tx_on_out,
    input wire logic              bus_bias_gnd_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    wire nrm = (mode_in == SCAW_MODE_NORMAL);
    wire low = mode_in inside {SCAW_MODE_STANDBY, SCAW_MODE_SLEEP};
    a_lwu_sticky: assert property (local_wake_flag_out && !local_wake_clr_in |=> local_wake_flag_out)
        else $error("local wake flag dropped");
    a_err_sticky: assert property (branch_tx_error_flag_out[0] && !branch_tx_error_clr_in[0] |=> branch_tx_error_flag_out[0])
        else $error("tx error flag dropped");
    a_irq_has_flag: assert property (wake_interrupt_out |-> local_wake_flag_out || inner_star_wake_flag_out)
        else $error("wake interrupt without flag");
    a_lwu_bias: assert property ($rose(local_wake_flag_out) |-> local_wake_pulldown_out)
        else $error("bias not pull-down on wake");
    a_err_gated: assert property ($rose(branch_tx_error_flag_out[0]) |-> $past(bus_tx_on_out))
        else $error("tx error outside transmission");
    a_gnd_bias: assert property (bus_bias_gnd_out == low)
        else $error("ground bias mismatch");
    a_off_rxd: assert property ((mode_in inside {SCAW_MODE_OFF, SCAW_MODE_RESET})[*4] |-> rxd_out)
        else $error("receive not high when off");
    a_uv_rxd: assert property ((io_uv_in && (low || nrm))[*4] |-> !rxd_out)
        else $error("receive not low on undervoltage");
    a_tx_mode: assert property ((!nrm)[*4] |-> !bus_tx_on_out)
        else $error("transmitter on outside normal");
    c_tx: cover property ($rose(bus_tx_on_out));
    c_lwu: cover property ($rose(local_wake_flag_out));
    c_isw: cover property ($rose(inner_star_wake_flag_out));
endmodule : scaw_props
bind scaw_core scaw_props u_props (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .mode_in(mode_in),
    .io_uv_in(io_uv_in), .local_wake_clr_in(local_wake_clr_in), .branch_tx_error_clr_in(branch_tx_error_clr_in),
    .rxd_out(rxd_out), .local_wake_pulldown_out(local_wake_pulldown_out), .local_wake_flag_out(local_wake_flag_out),
    .inner_star_wake_flag_out(inner_star_wake_flag_out), .branch_tx_error_flag_out(branch_tx_error_flag_out),
    .wake_interrupt_out(wake_interrupt_out), .bus_tx_on_out(bus_tx_on_out), .bus_bias_gnd_out(bus_bias_gnd_out));

// ### tb.sv
// self-checking bench for the star activity and wake core
`timescale 1ns/1ps
module tb;
    import scaw_pkg::*;
    logic clk = 0, rst = 1, uv = 0, txd = 1, ten = 1, bge = 1, lw = 1, lwc = 0, isc = 0;
    logic rxd, pd, txon, flt, lwf, iwf, ba, ta, ia, fr, wi, gnd;
    logic [1:0] ec = 0, pull = 0, ln, oe, ef, lo, ev;
    scaw_mode_e md = SCAW_MODE_NORMAL;
    scaw_sym_e sym;
    scaw_branch_s [NUM_BR-1:0] br = '0;
    int fail_count = 0, n_tests = 0;
    scaw_peer peer (.dut_oe_in(oe), .pull_in(pull), .line_out(ln));
    scaw_core uut (.clock_in(clk), .sys_rst_in(rst), .mode_in(md), .io_uv_in(uv), .txd_in(txd),
        .tx_en_n_in(ten), .bus_guard_en_in(bge), .rxd_out(rxd), .local_wake_in(lw), .local_wake_pulldown_out(pd),
        .inner_star_line0_in(ln[0]), .inner_star_line1_in(ln[1]), .inner_star_line0_out(lo[0]),
        .inner_star_line0_oe_out(oe[0]), .inner_star_line1_out(lo[1]), .inner_star_line1_oe_out(oe[1]),
        .branch_in(br), .bus_sym_out(sym), .bus_tx_on_out(txon), .bus_bias_gnd_out(gnd), .bus_float_out(flt),
        .local_wake_clr_in(lwc), .inner_star_wake_clr_in(isc), .branch_tx_error_clr_in(ec),
        .local_wake_flag_out(lwf), .inner_star_wake_flag_out(iwf), .branch_tx_error_flag_out(ef),
        .wake_interrupt_out(wi), .branch_event_interrupt_out(ev), .bus_active_out(ba), .tx_active_out(ta),
        .inner_star_active_out(ia), .fifo_ready_out(fr));
    initial
    begin
        forever #20 clk = ~clk;
    end
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task chk(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    task print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    initial
    begin
        #(40 * 9000);
        fail_count++;
        print_verdict();
    end
    initial
    begin
        cyc(12);
        rst = 0;
        // guardian low blocks the start even with a falling edge
        bge = 0; ten = 0; cyc(8); txd = 0; cyc(8);
        chk(txon, 0);
        txd = 1; ten = 1; cyc(10); bge = 1; ten = 0; cyc(8); txd = 0; cyc(8);
        chk({rxd, sym, txon, oe, ta}, {1'b0, SCAW_SYM_D0, 1'b1, 2'b01, 1'b1});
        chk({lo, fr}, 3'b001);
        txd = 1; cyc(6);
        chk({rxd, sym, oe}, {1'b1, SCAW_SYM_D1, 2'b10});
        for (int k = 0; k < 3; k++)
        begin
            br[0] = 6'h04 >> k; cyc(1);
            chk(ev, 2'b01);
            cyc(2); br[0] = '0; cyc(1);
            chk(ef[0], 1);
            ec[0] = 1; cyc(1); ec[0] = 0; cyc(1);
            chk(ef[0], 0);
        end
        ten = 1; cyc(12);
        chk({rxd, sym, txon, oe, ta}, {1'b1, SCAW_SYM_IDLE, 1'b0, 2'b00, 1'b0});
        $display("test transmit done");
        br[0] = 6'h28; cyc(12);
        chk({rxd, oe, ba}, {1'b0, 2'b01, 1'b1});
        br[0] = 6'h30; cyc(6);
        chk({rxd, oe}, {1'b1, 2'b10});
        // gaps stay short; slower senders use the plain pattern
        br[0] = '0; cyc(3); br[0] = 6'h30; cyc(3);
        chk({ba, rxd}, 2'b11);
        uv = 1; cyc(6);
        chk(rxd, 0);
        uv = 0; br[0] = '0; cyc(16);
        chk({rxd, oe, ba}, {1'b1, 2'b00, 1'b0});
        $display("test bus input done");
        pull = 2'b01; cyc(10);
        chk({rxd, sym, ia}, {1'b0, SCAW_SYM_D0, 1'b1});
        pull = 2'b10; cyc(10);
        chk({rxd, sym}, {1'b1, SCAW_SYM_D1});
        pull = 2'b11; cyc(10);
        chk({rxd, sym, iwf}, {1'b0, SCAW_SYM_D0, 1'b1});
        pull = 0; isc = 1; cyc(14); isc = 0;
        chk({rxd, sym, ia, iwf}, {1'b1, SCAW_SYM_IDLE, 1'b0, 1'b0});
        pull = 2'b10; cyc(20); pull = 0; cyc(1); pull = 2'b10; cyc(20); pull = 0;
        chk(iwf, 0);
        $display("test inner star done");
        md = SCAW_MODE_STANDBY; cyc(2); br[0] = 6'h02; cyc(6);
        chk({ef, gnd}, 3'b001);
        br[0] = '0; lw = 0; cyc(1249);
        chk(lwf, 0);
        cyc(1);
        chk({lwf, pd, wi}, 3'b111);
        lwc = 1; cyc(1); lwc = 0; lw = 1; cyc(1260);
        chk({lwf, pd}, 2'b00);
        md = SCAW_MODE_OFF; cyc(6);
        chk({rxd, flt, gnd}, 3'b110);
        $display("test wake and modes done");
        print_verdict();
    end
endmodule : tb
